// ---- verilog/btc_regs.svh ----
`ifndef BTC_REGS_SVH
`define BTC_REGS_SVH

// ************************************************************
// register byte offsets inside the system manager block
// ************************************************************
`define BTC_BOD_CTRL_OFS   12'h018
`define BTC_TEMP_CTRL_OFS  12'h01C
`define BTC_WPROT_OFS      12'h100

// ************************************************************
// field positions
// ************************************************************
`define BTC_BROWNOUT_DETECTOR_ENABLE_BIT     0
`define BTC_BROWNOUT_THRESHOLD_SEL_LSB     1
`define BTC_BROWNOUT_THRESHOLD_SEL_MSB     2
`define BTC_TEMP_EN_BIT    0
`define BTC_CFG_BROWNOUT_DETECTOR_ENABLE_BIT 23
`define BTC_CFG_VL_LSB     21
`define BTC_CFG_VL_MSB     22

// ************************************************************
// reset values and unlock keys
// ************************************************************
`define BTC_TEMP_CTRL_RST  32'h0000_0000
`define BTC_RD_ZERO        32'h0000_0000
`define BTC_KEY1           8'h59
`define BTC_KEY2           8'h16
`define BTC_KEY3           8'h88

// ************************************************************
// threshold codes and their levels in millivolts
// ************************************************************
`define BTC_VL_4V4         2'h3
`define BTC_VL_3V7         2'h2
`define BTC_VL_2V7         2'h1
`define BTC_VL_2V2         2'h0
`define BTC_MV_4V4         16'h1130
`define BTC_MV_3V7         16'h0E74
`define BTC_MV_2V7         16'h0A8C
`define BTC_MV_2V2         16'h0898

`endif

// ---- verilog/btc_pkg.sv ----
// ************************************************************
// shared types of the brown-out and temperature sensor control
// ************************************************************
package btc_pkg;
  // progress through the three-key unlock sequence
  typedef enum logic [1:0] {
    LOCK_IDLE,
    LOCK_KEY1_OK,
    LOCK_KEY2_OK,
    LOCK_OPEN
  } btc_lock_state_type;
endpackage

// ---- verilog/btc_ctl_if.sv ----
`timescale 1ns/1ns
// ************************************************************
// internal carrier between register front end and sub-blocks
// ************************************************************
interface btc_ctl_if;
  logic        prot_wr;    // write strobe to the protection register
  logic        bod_wr;     // write strobe to the brown-out control register
  logic [31:0] wdata;      // bus write data
  logic        unlocked;   // protected bits may be written
  logic        brownout_detector_enable;     // stored detector enable
  logic [1:0]  brownout_threshold_sel;     // stored threshold code
  logic        cfg_loaded; // defaults taken from the configuration word
  modport master (output prot_wr, bod_wr, wdata, input unlocked, brownout_detector_enable, brownout_threshold_sel, cfg_loaded);
  modport lock   (input prot_wr, wdata, output unlocked);
  modport bod    (input bod_wr, wdata, unlocked, output brownout_detector_enable, brownout_threshold_sel, cfg_loaded);
endinterface // btc_ctl_if

// ---- verilog/btc_unlock.sv ----
`timescale 1ns/1ns
`include "btc_regs.svh"
// ************************************************************
// three-key write protection unlock
// ************************************************************
module btc_unlock (
  input  wire logic sys_clk_i, // system clock
  input  wire logic rst_n_i,   // synchronised reset, active low
  btc_ctl_if.lock   ctl        // strobes in, unlock state out
);
  btc_pkg::btc_lock_state_type state_q; // sequence progress
  logic [7:0]                  key;     // low byte of the write

  assign key = ctl.wdata[7:0];

  // advance on each protection write; a wrong key restarts the search
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= btc_pkg::LOCK_IDLE;
    end else if (ctl.prot_wr) begin
      case (state_q)
        btc_pkg::LOCK_IDLE:    state_q <= (key == `BTC_KEY1) ? btc_pkg::LOCK_KEY1_OK : btc_pkg::LOCK_IDLE;
        btc_pkg::LOCK_KEY1_OK: state_q <= (key == `BTC_KEY2) ? btc_pkg::LOCK_KEY2_OK :
                                          (key == `BTC_KEY1) ? btc_pkg::LOCK_KEY1_OK : btc_pkg::LOCK_IDLE;
        btc_pkg::LOCK_KEY2_OK: state_q <= (key == `BTC_KEY3) ? btc_pkg::LOCK_OPEN :
                                          (key == `BTC_KEY1) ? btc_pkg::LOCK_KEY1_OK : btc_pkg::LOCK_IDLE;
        default:               state_q <= btc_pkg::LOCK_IDLE; // any write while open locks again
      endcase
    end
  end

  assign ctl.unlocked = (state_q == btc_pkg::LOCK_OPEN);

  // the three keys back to back from locked
  sequence s_keys;
    ctl.prot_wr && key == `BTC_KEY1 && !ctl.unlocked ##1
    ctl.prot_wr && key == `BTC_KEY2 ##1
    ctl.prot_wr && key == `BTC_KEY3;
  endsequence

  property p_unlock_seq;
    @(posedge sys_clk_i) disable iff (!rst_n_i) s_keys |=> ctl.unlocked;
  endproperty
  a_unlock_seq: assert property (p_unlock_seq) else $error("unlock keys did not open");

  property p_open_cause;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(ctl.unlocked) |-> $past(ctl.prot_wr) && $past(key) == `BTC_KEY3;
  endproperty
  a_open_cause: assert property (p_open_cause) else $error("unlock without third key");
endmodule // btc_unlock

// ---- verilog/btc_bod_ctrl.sv ----
`timescale 1ns/1ns
`include "btc_regs.svh"
// ************************************************************
// protected brown-out enable and threshold bits
// ************************************************************
module btc_bod_ctrl (
  input  wire logic        sys_clk_i, // system clock
  input  wire logic        rst_n_i,   // synchronised reset, active low
  input  wire logic [31:0] cfg_i,     // user configuration word 0
  btc_ctl_if.bod           ctl        // strobes in, stored bits out
);
  logic       loaded_q; // defaults taken after reset
  logic       en_q;     // detector enable
  logic [1:0] vl_q;     // threshold code

  // first edge after reset marks defaults as loaded
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loaded_q <= 1'b0;
    end else begin
      loaded_q <= 1'b1;
    end
  end

  // defaults from the configuration word, then protected writes only
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_q <= 1'b0;
      vl_q <= 2'h0;
    end else if (!loaded_q) begin
      en_q <= cfg_i[`BTC_CFG_BROWNOUT_DETECTOR_ENABLE_BIT];
      vl_q <= cfg_i[`BTC_CFG_VL_MSB:`BTC_CFG_VL_LSB];
    end else if (ctl.bod_wr && ctl.unlocked) begin
      en_q <= ctl.wdata[`BTC_BROWNOUT_DETECTOR_ENABLE_BIT];
      vl_q <= ctl.wdata[`BTC_BROWNOUT_THRESHOLD_SEL_MSB:`BTC_BROWNOUT_THRESHOLD_SEL_LSB];
    end
  end

  assign ctl.brownout_detector_enable     = en_q;
  assign ctl.brownout_threshold_sel     = vl_q;
  assign ctl.cfg_loaded = loaded_q;

  property p_cfg_load;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(loaded_q) |-> en_q == $past(cfg_i[`BTC_CFG_BROWNOUT_DETECTOR_ENABLE_BIT])
                          && vl_q == $past(cfg_i[`BTC_CFG_VL_MSB:`BTC_CFG_VL_LSB]);
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("defaults not taken from config");

  property p_locked_hold;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      ctl.bod_wr && !ctl.unlocked && loaded_q |=> $stable(en_q) && $stable(vl_q);
  endproperty
  a_locked_hold: assert property (p_locked_hold) else $error("locked write changed bits");

  property p_open_write;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      ctl.bod_wr && ctl.unlocked && loaded_q |=> en_q == $past(ctl.wdata[0]) && vl_q == $past(ctl.wdata[2:1]);
  endproperty
  a_open_write: assert property (p_open_write) else $error("unlocked write not stored");
endmodule // btc_bod_ctrl

// ---- verilog/btc_top.sv ----
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "btc_regs.svh"

// ************************************************************
// brown-out and temperature sensor control register bank
// ************************************************************
module btc_top (
  input  wire logic        sys_clk_i,                // 20 MHz system clock
  input  wire logic        rstn_i,                   // chip reset, active low, asynchronous
  input  wire logic [31:0] user_config_word0_i,      // flash user configuration word 0
  input  wire logic [11:0] addr_i,                   // register byte address
  input  wire logic [31:0] wdata_i,                  // write data
  input  wire logic        wr_i,                     // write strobe
  input  wire logic        rd_i,                     // read strobe
  output logic      [31:0] rd_data_o,                // read data, cycle after the strobe
  output logic             brownout_detector_enable_o, // detector on
  output logic      [1:0]  brownout_threshold_sel_o, // threshold code
  output logic      [15:0] brownout_level_mv_o,      // selected level in millivolts
  output logic             temp_sensor_enable_o,     // temperature sensor on
  output logic             write_unlocked_o          // protected bits writable
);

  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_meta_q; // first release stage
  logic rst_q;      // released reset used by all logic

  // assert at once, release after two edges
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_q <= 1'b0;
      rst_q      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q      <= rst_meta_q;
    end
  end

  // ************************************************************
  // address decode
  // ************************************************************
  btc_ctl_if ctl (); // carrier to the sub-blocks

  logic hit_bod;  // brown-out control selected
  logic hit_temp; // temperature control selected
  logic hit_prot; // protection register selected

  // one register per aligned word; anything else is unmapped
  always_comb begin
    hit_bod  = 1'b0;
    hit_temp = 1'b0;
    hit_prot = 1'b0;
    if (addr_i == `BTC_BOD_CTRL_OFS) begin
      hit_bod = 1'b1;
    end else if (addr_i == `BTC_TEMP_CTRL_OFS) begin
      hit_temp = 1'b1;
    end else if (addr_i == `BTC_WPROT_OFS) begin
      hit_prot = 1'b1;
    end
  end

  // write strobes handed to the sub-blocks
  assign ctl.prot_wr = wr_i && hit_prot;
  assign ctl.bod_wr  = wr_i && hit_bod;
  assign ctl.wdata   = wdata_i;

  // ************************************************************
  // sub-blocks
  // ************************************************************
  // unlock sequence over the protection register
  btc_unlock u_unlock (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_q),
    .ctl       (ctl)
  );

  // protected brown-out bits
  btc_bod_ctrl u_bod (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_q),
    .cfg_i     (user_config_word0_i),
    .ctl       (ctl)
  );

  // ************************************************************
  // temperature sensor control
  // ************************************************************
  logic temp_en_q; // sensor enable, the only live bit

  // plain read/write bit, cleared by any reset
  always_ff @(posedge sys_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      temp_en_q <= 1'(`BTC_TEMP_CTRL_RST);
    end else if (wr_i && hit_temp) begin
      temp_en_q <= wdata_i[`BTC_TEMP_EN_BIT];
    end
  end

  // sensor output feeds the converter's alternative channel 7 input
  assign temp_sensor_enable_o = temp_en_q;

  // ************************************************************
  // brown-out outputs
  // ************************************************************
  logic [15:0] level_mv_q; // decoded threshold level

  // threshold code to detection level
  always_ff @(posedge sys_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      level_mv_q <= `BTC_MV_2V2;
    end else begin
      case (ctl.brownout_threshold_sel)
        `BTC_VL_4V4: level_mv_q <= `BTC_MV_4V4;
        `BTC_VL_3V7: level_mv_q <= `BTC_MV_3V7;
        `BTC_VL_2V7: level_mv_q <= `BTC_MV_2V7;
        default:     level_mv_q <= `BTC_MV_2V2;
      endcase
    end
  end

  assign brownout_detector_enable_o = ctl.brownout_detector_enable;
  assign brownout_threshold_sel_o   = ctl.brownout_threshold_sel;
  assign brownout_level_mv_o        = level_mv_q;
  assign write_unlocked_o           = ctl.unlocked;

  // ************************************************************
  // read path
  // ************************************************************
  logic [31:0] rd_mux;    // selected register image
  logic [31:0] rd_data_q; // read data, held for one cycle only

  // register images; reserved bits read as zero
  always_comb begin
    rd_mux = `BTC_RD_ZERO;
    if (hit_bod) begin
      rd_mux[`BTC_BROWNOUT_DETECTOR_ENABLE_BIT]                  = ctl.brownout_detector_enable;
      rd_mux[`BTC_BROWNOUT_THRESHOLD_SEL_MSB:`BTC_BROWNOUT_THRESHOLD_SEL_LSB]  = ctl.brownout_threshold_sel;
    end else if (hit_temp) begin
      rd_mux[`BTC_TEMP_EN_BIT] = temp_en_q;
    end else if (hit_prot) begin
      rd_mux[0] = ctl.unlocked;                           // shows lock state
    end
  end

  // data stand in the cycle after the strobe and read zero otherwise
  always_ff @(posedge sys_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      rd_data_q <= `BTC_RD_ZERO;
    end else if (rd_i) begin
      rd_data_q <= rd_mux;
    end else begin
      rd_data_q <= `BTC_RD_ZERO;
    end
  end

  assign rd_data_o = rd_data_q;

  // ************************************************************
  // checks
  // ************************************************************
  property p_temp_reset;
    @(posedge sys_clk_i) disable iff (!rst_q) $rose(rst_q) |-> !temp_en_q;
  endproperty
  a_temp_reset: assert property (p_temp_reset) else $error("sensor enable not clear after reset");

  property p_temp_write;
    @(posedge sys_clk_i) disable iff (!rst_q)
      wr_i && hit_temp |=> temp_sensor_enable_o == $past(wdata_i[0]);
  endproperty
  a_temp_write: assert property (p_temp_write) else $error("sensor enable write lost");

  property p_temp_read;
    @(posedge sys_clk_i) disable iff (!rst_q)
      rd_i && addr_i == `BTC_TEMP_CTRL_OFS |=> rd_data_o == {31'h0000_0000, temp_en_q}
                                           ##1 (rd_data_o == 32'h0000_0000 || rd_i);
  endproperty
  a_temp_read: assert property (p_temp_read) else $error("sensor register read wrong");

  property p_level_map;
    @(posedge sys_clk_i) disable iff (!rst_q)
      ##1 level_mv_q == (($past(ctl.brownout_threshold_sel) == 2'h3) ? 16'h1130 : ($past(ctl.brownout_threshold_sel) == 2'h2) ? 16'h0E74 :
                         ($past(ctl.brownout_threshold_sel) == 2'h1) ? 16'h0A8C : 16'h0898);
  endproperty
  a_level_map: assert property (p_level_map) else $error("threshold level mismatch");
endmodule // btc_top

// ---- dv/btc_tb_top.sv ----
`timescale 1ns/1ns
`include "btc_regs.svh"
// ************************************************************
// self-checking bench for the brown-out and temperature control
// ************************************************************
module btc_tb_top;
  logic        sys_clk;    // 20 MHz bench clock
  logic        rstn;       // chip reset, active low
  logic [31:0] cfg;        // user configuration word 0
  logic [11:0] addr;       // bus address
  logic [31:0] wdata;      // bus write data
  logic        wr;         // write strobe
  logic        rd;         // read strobe
  logic [31:0] rd_data;    // bus read data
  logic        brownout_detector_enable;     // detector enable output
  logic [1:0]  brownout_threshold_sel;     // threshold code output
  logic [15:0] level_mv;   // threshold level output
  logic        temp_en;    // sensor enable output
  logic        unlocked;   // protection state output
  int          mismatches; // failed comparisons
  int          tests_run;  // comparisons made
  int          cycles;     // watchdog count
  int          m_en;       // model detector enable
  int          m_vl;       // model threshold code
  int          m_temp;     // model sensor enable
  int          m_unl;      // model unlock state
  int          m_stage;    // model keys accepted so far

  btc_top dut (
    .sys_clk_i                  (sys_clk),
    .rstn_i                     (rstn),
    .user_config_word0_i        (cfg),
    .addr_i                     (addr),
    .wdata_i                    (wdata),
    .wr_i                       (wr),
    .rd_i                       (rd),
    .rd_data_o                  (rd_data),
    .brownout_detector_enable_o (brownout_detector_enable),
    .brownout_threshold_sel_o   (brownout_threshold_sel),
    .brownout_level_mv_o        (level_mv),
    .temp_sensor_enable_o       (temp_en),
    .write_unlocked_o           (unlocked)
  );

  // ************************************************************
  // clock and watchdog
  // ************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // cut a hang short well beyond the expected run length
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles >= 4000) begin
      mismatches++;
      stop_test();
    end
  end

  // ************************************************************
  // model, bus tasks and comparisons
  // ************************************************************
  // expected level in millivolts for a threshold code
  function automatic logic [15:0] mv_of(input int c);
    case (c)
      3:       return 16'h1130; // 4.4 V
      2:       return 16'h0E74; // 3.7 V
      1:       return 16'h0A8C; // 2.7 V
      default: return 16'h0898; // 2.2 V
    endcase
  endfunction

  // expected read value of an address
  function automatic logic [31:0] exp_rd(input logic [11:0] a);
    case (a)
      12'h018: return 32'(m_vl * 2 + m_en);
      12'h01C: return 32'(m_temp);
      12'h100: return 32'(m_unl);
      default: return 32'h0000_0000; // unmapped reads as zero
    endcase
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // one bus write, model updated at the edge that takes it
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
    if (a == 12'h100) begin
      if (m_unl != 0) begin // any write while open locks again
        m_unl   = 0;
        m_stage = 0;
      end else if (m_stage == 1 && d[7:0] == 8'h16) m_stage = 2;
      else if (m_stage == 2 && d[7:0] == 8'h88) begin
        m_unl   = 1;
        m_stage = 0;
      end else m_stage = (d[7:0] == 8'h59) ? 1 : 0;
    end else if (a == 12'h018 && m_unl != 0) begin // locked writes dropped
      m_en = int'(d[0]);
      m_vl = int'(d[2:1]);
    end else if (a == 12'h01C) m_temp = int'(d[0]);
  endtask

  // read, compare, then check that the data does not stand a second cycle
  task automatic check_rd(input logic [11:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    @(negedge sys_clk);
    cmp(rd_data, exp_rd(a), "read data");
    @(negedge sys_clk);
    cmp(rd_data, 32'h0000_0000, "read data held");
  endtask

  // compare all control outputs once the level has caught up
  task automatic check_outs();
    repeat (2) @(negedge sys_clk);
    cmp(32'(brownout_detector_enable), 32'(m_en), "detector enable");
    cmp(32'(brownout_threshold_sel), 32'(m_vl), "threshold code");
    cmp(32'(level_mv), 32'(mv_of(m_vl)), "threshold level");
    cmp(32'(temp_en), 32'(m_temp), "sensor enable");
    cmp(32'(unlocked), 32'(m_unl), "unlock state");
  endtask

  // reset with a new configuration word, checking outputs inside reset
  task automatic do_reset(input logic [31:0] c);
    @(posedge sys_clk);
    rstn <= 1'b0;
    cfg  <= c;
    repeat (3) @(negedge sys_clk);
    cmp(32'(temp_en), 32'h0000_0000, "sensor enable in reset");
    cmp(32'(unlocked), 32'h0000_0000, "unlock in reset");
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge sys_clk);
    m_en    = int'(c[23]);
    m_vl    = int'(c[22:21]);
    m_temp  = 0;
    m_unl   = 0;
    m_stage = 0;
  endtask

  task automatic stop_test();
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  logic [7:0] bad_keys[2] = '{8'h59, 8'h88};                 // out of order
  logic [7:0] good_keys[5] = '{8'h59, 8'h16, 8'h59, 8'h16, 8'h88}; // restart then full

  initial begin
    rstn = 1'b0;
    cfg = 32'h0000_0000;
    addr = 12'h000;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    void'($urandom(32'he894_1ec6));
    do_reset($urandom());
    check_outs();
    check_rd(12'h01C);
    check_rd(12'h018);
    @(posedge sys_clk);
    cfg <= ~cfg; // defaults are taken once only
    check_outs();
    bus_wr(12'h018, $urandom());
    check_outs();
    foreach (bad_keys[i]) bus_wr(12'h100, 32'(bad_keys[i]));
    bus_wr(12'h018, ~exp_rd(12'h018));
    check_rd(12'h018);
    check_rd(12'h100);
    foreach (good_keys[i]) bus_wr(12'h100, 32'(good_keys[i]));
    check_rd(12'h100);
    for (int c = 0; c < 4; c++) begin // every threshold code, both enables
      bus_wr(12'h018, 32'({$urandom(), 3'h0}) | 32'(c * 2 + (c % 2)));
      check_outs();
      check_rd(12'h018);
    end
    bus_wr(12'h100, 32'h0000_0000); // relocks
    bus_wr(12'h018, ~exp_rd(12'h018));
    check_outs();
    for (int i = 0; i < 4; i++) begin // random sensor enable writes, each checked and read back
      bus_wr(12'h01C, $urandom());
      check_outs();
      check_rd(12'h01C);
    end
    bus_wr(12'h01C, 32'h0000_0001);
    bus_wr(12'h044, $urandom()); // unmapped write is dropped
    check_rd(12'h044);
    check_outs();
    foreach (good_keys[i]) bus_wr(12'h100, 32'(good_keys[i]));
    do_reset($urandom()); // mid-run reset with sensor on and open lock
    check_outs();
    check_rd(12'h01C);
    stop_test();
  end
endmodule // btc_tb_top
